// file: hw/asr_host.sv
// Purpose : clocked host that runs read and write cycles on an async sram
// Assumes : data pins sampled as synchronous inputs; one request at a time
// Notes   : writes use the output-disable style: drive off, wait, then strobe
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - address register is frozen for the whole read cycle.
// - read drives select low, output drive low, strobe high; memory returns data.
// - back-to-back reads may keep select low and just change address.
// - address pins always come from flip-flops, never floated.
// - write keeps address stable, select low, strobe low at least 160 ns.
// - write data set up before and held after strobe rising edge.
// - strobe stays high whenever address changes.
// - host never drives data while memory may still drive after strobe falls.
// - raise output drive, wait output-disable delay, then drive write data.
// - write data held for hold time after strobe rises.
// - retention input forces select high while idle and blocks new cycles.
// - strobe low pulse lasts at least 160 ns.
module asr_host (
    input  wire logic                      CORE_CLK_IN,
    input  wire logic                      RST_IN,
    input  wire logic                      CLK_EN_IN,
    input  wire logic                      REQ_VALID_IN,
    input  wire asr_pkg::asr_req_s         REQ_IN,
    input  wire logic                      RETAIN_IN,
    input  wire logic [asr_pkg::DATA_W-1:0] DQ_IN,
    output var  logic                      REQ_READY_OUT,
    output var  logic                      RD_VALID_OUT,
    output var  logic [asr_pkg::DATA_W-1:0] RD_DATA_OUT,
    output var  logic                      WR_DONE_OUT,
    output var  asr_pkg::asr_pins_s        PINS_OUT,
    output var  logic [asr_pkg::DATA_W-1:0] DQ_OUT,
    output var  logic                      DQ_OE_OUT
);
    // ============================================================
    // state
    asr_pkg::asr_state_e           state_r, state_nxt;
    logic [asr_pkg::CNT_W-1:0]     cnt_r, cnt_nxt;
    asr_pkg::asr_pins_s            pins_r, pins_nxt;
    logic [asr_pkg::DATA_W-1:0]    wdata_r, wdata_nxt;
    logic                          oe_r, oe_nxt;
    logic                          rdv_r, rdv_nxt;
    logic                          wdone_r, wdone_nxt;
    logic [asr_pkg::DATA_W-1:0]    rdata_r, rdata_nxt;
    logic                          ready_r, ready_nxt;

    function automatic logic [asr_pkg::CNT_W-1:0] cyc(input int n);
        cyc = (asr_pkg::CNT_W)'(n - 1);
    endfunction : cyc

    // ============================================================
    // decode
    // counter parks at zero so a state that waits on it never wraps
    wire cnt_done   = (cnt_r == '0);
    wire cnt_dec_ok = !cnt_done;
    wire take       = ready_r && REQ_VALID_IN && !RETAIN_IN;
    wire [asr_pkg::CNT_W-1:0] cnt_dec = cnt_r - 6'h01;

    // ============================================================
    // next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_dec_ok ? cnt_dec : cnt_r;
        pins_nxt  = pins_r;
        wdata_nxt = wdata_r;
        oe_nxt    = oe_r;
        rdv_nxt   = 1'b0;
        wdone_nxt = 1'b0;
        rdata_nxt = rdata_r;
        ready_nxt = ready_r;
        case (state_r)
            asr_pkg::ASR_IDLE: begin
                // select may stay low between reads
                if (RETAIN_IN) begin
                    pins_nxt.cs_n = 1'b1;
                    pins_nxt.oe_n = 1'b1;
                end
                if (take) begin
                    pins_nxt.addr = REQ_IN.addr;  // strobe is high here
                    pins_nxt.cs_n = 1'b0;
                    ready_nxt     = 1'b0;
                    if (REQ_IN.write) begin
                        // output drive off first so memory releases the bus
                        pins_nxt.oe_n = 1'b1;
                        wdata_nxt     = REQ_IN.wdata;
                        cnt_nxt       = cyc(asr_pkg::SETUP_CYC);
                        state_nxt     = asr_pkg::ASR_WSETUP;
                    end else begin
                        pins_nxt.oe_n = 1'b0;
                        pins_nxt.we_n = 1'b1;
                        cnt_nxt       = cyc(asr_pkg::ACCESS_CYC);
                        state_nxt     = asr_pkg::ASR_RD;
                    end
                end
            end
            asr_pkg::ASR_RD: begin
                // address held untouched until data is sampled
                if (cnt_done) begin
                    rdata_nxt = DQ_IN;
                    rdv_nxt   = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = asr_pkg::ASR_IDLE;
                end
            end
            asr_pkg::ASR_WSETUP: begin
                if (cnt_done) begin
                    cnt_nxt   = cyc(asr_pkg::HIZ_WAIT_CYC);
                    state_nxt = asr_pkg::ASR_WHIZ;
                end
            end
            asr_pkg::ASR_WHIZ: begin
                // drive data only after the output-disable delay
                if (cnt_done) begin
                    oe_nxt        = 1'b1;
                    pins_nxt.we_n = 1'b0;
                    cnt_nxt       = cyc(asr_pkg::STORE_PULSE_CYC);
                    state_nxt     = asr_pkg::ASR_WPULSE;
                end
            end
            asr_pkg::ASR_WPULSE: begin
                // data driven for the whole pulse covers setup
                if (cnt_done) begin
                    pins_nxt.we_n = 1'b1;
                    cnt_nxt       = cyc(asr_pkg::HOLD_CYC);
                    state_nxt     = asr_pkg::ASR_WHOLD;
                end
            end
            asr_pkg::ASR_WHOLD: begin
                if (cnt_done) begin
                    oe_nxt    = 1'b0;
                    cnt_nxt   = cyc(asr_pkg::RECOVERY_CYC);
                    state_nxt = asr_pkg::ASR_WREC;
                end
            end
            asr_pkg::ASR_WREC: begin
                // address may not move right after strobe rises
                if (cnt_done) begin
                    wdone_nxt = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = asr_pkg::ASR_IDLE;
                end
            end
            default: begin
                state_nxt = asr_pkg::ASR_IDLE;
                ready_nxt = 1'b1;
                oe_nxt    = 1'b0;
                pins_nxt  = asr_pkg::PINS_IDLE;
            end
        endcase
    end

    // ============================================================
    // registers
    // reset and enable repeat per group so each block stays small
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            state_r <= asr_pkg::ASR_IDLE;
            cnt_r   <= '0;
        end else if (CLK_EN_IN) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // pins leave reset deselected so the memory never sees a stray strobe
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            pins_r <= asr_pkg::PINS_IDLE;
        end else if (CLK_EN_IN) begin
            pins_r <= pins_nxt;
        end
    end

    // write data and its drive enable; drive starts off to avoid contention
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            wdata_r <= '0;
            oe_r    <= 1'b0;
        end else if (CLK_EN_IN) begin
            wdata_r <= wdata_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // answer pulses and the ready level
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            rdv_r   <= 1'b0;
            wdone_r <= 1'b0;
            ready_r <= 1'b1;
        end else if (CLK_EN_IN) begin
            rdv_r   <= rdv_nxt;
            wdone_r <= wdone_nxt;
            ready_r <= ready_nxt;
        end
    end

    // read data holds until the next read replaces it
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            rdata_r <= '0;
        end else if (CLK_EN_IN) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign REQ_READY_OUT = ready_r;
    assign RD_VALID_OUT  = rdv_r;
    assign RD_DATA_OUT   = rdata_r;
    assign WR_DONE_OUT   = wdone_r;
    assign PINS_OUT      = pins_r;
    assign DQ_OUT        = wdata_r;
    assign DQ_OE_OUT     = oe_r;
endmodule : asr_host

`default_nettype wire

// file: hw/asr_pkg.sv
// Purpose : shared constants and types for the async sram host controller
// Assumes : 100 MHz core clock, 2048 x 8 asynchronous static memory
// Notes   : times are in ns; cycle counts derive from them
package asr_pkg;
    // ============================================================
    // geometry
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    // ============================================================
    // timing
    localparam int CLK_PERIOD_NS         = 10;
    localparam int STORE_PULSE_MIN_NS    = 160;
    localparam int WRITE_DATA_SETUP_NS   = 160;
    localparam int WRITE_DATA_HOLD_NS    = 30;
    localparam int STROBE_TO_HIZ_NS      = 60;
    localparam int OUTPUT_DISABLE_NS     = 40;
    localparam int ADDR_ACCESS_NS        = 160;
    localparam int ADDR_SETUP_NS         = 20;
    localparam int WRITE_RECOVERY_NS     = 20;
    localparam int CYCLE_TIME_NS         = 200;
    // least times round up
    localparam int STORE_PULSE_CYC  = (STORE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC         = (WRITE_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIZ_WAIT_CYC     = (OUTPUT_DISABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC        = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC     = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // read waits the full cycle time, not only the address access time
    localparam int ACCESS_CYC       = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W            = 6;
    // ============================================================
    // types
    typedef enum logic [2:0] {
        ASR_IDLE   = 3'b000,
        ASR_RD     = 3'b001,
        ASR_WSETUP = 3'b010,
        ASR_WHIZ   = 3'b011,
        ASR_WPULSE = 3'b100,
        ASR_WHOLD  = 3'b101,
        ASR_WREC   = 3'b110
    } asr_state_e;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asr_req_s;

    typedef struct packed {
        logic              cs_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
    } asr_pins_s;

    // controls deselected and strobe high; the address value is arbitrary
    localparam asr_pins_s PINS_IDLE = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
endpackage : asr_pkg

// file: verification/asr_host_monitor.sv
// Purpose : port-level checker for asr_host
// Assumes : CLK_EN_IN held high while cycles run
// Notes   : bound to the host from the bench top
`timescale 1ns/1ns
`default_nettype none
module asr_host_chk (
    input wire logic               CORE_CLK_IN,
    input wire logic               RST_IN,
    input wire logic               CLK_EN_IN,
    input wire logic               REQ_VALID_IN,
    input wire asr_pkg::asr_req_s  REQ_IN,
    input wire logic               RETAIN_IN,
    input wire logic               REQ_READY_OUT,
    input wire logic               RD_VALID_OUT,
    input wire logic               WR_DONE_OUT,
    input wire asr_pkg::asr_pins_s PINS_OUT,
    input wire logic [7:0]         DQ_OUT,
    input wire logic               DQ_OE_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    wire tk = CLK_EN_IN && REQ_VALID_IN && REQ_READY_OUT && !RETAIN_IN;
    // ============================================================
    // sequences
    sequence s_low8; (!PINS_OUT.we_n && !PINS_OUT.cs_n) [*8]; endsequence
    sequence s_adr8; $stable(PINS_OUT.addr) [*8]; endsequence
    sequence s_hold3; (DQ_OE_OUT && $stable(DQ_OUT)) [*3]; endsequence
    // ============================================================
    // properties
    property p_rd_sel;
        tk && !REQ_IN.write |=> !PINS_OUT.cs_n && !PINS_OUT.oe_n && PINS_OUT.we_n
            && PINS_OUT.addr == $past(REQ_IN.addr);
    endproperty
    property p_rd_adr; tk && !REQ_IN.write |=> ##1 s_adr8 ##1 s_adr8; endproperty
    property p_rd_ans; tk && !REQ_IN.write |-> ##21 RD_VALID_OUT && REQ_READY_OUT; endproperty
    property p_wr_ans; tk && REQ_IN.write |-> ##28 WR_DONE_OUT && REQ_READY_OUT; endproperty
    property p_pulse; $fell(PINS_OUT.we_n) |-> s_low8 ##1 s_low8 ##1 PINS_OUT.we_n; endproperty
    property p_adr_w; !PINS_OUT.we_n |-> $stable(PINS_OUT.addr); endproperty
    property p_oe_first;
        $rose(DQ_OE_OUT) |-> PINS_OUT.oe_n && $past(PINS_OUT.oe_n, 4);
    endproperty
    property p_hold; $rose(PINS_OUT.we_n) |-> s_hold3 ##1 !DQ_OE_OUT; endproperty
    property p_setup; $rose(PINS_OUT.we_n) |-> $past(DQ_OE_OUT, 16); endproperty
    property p_retain;
        RETAIN_IN && REQ_READY_OUT && CLK_EN_IN |=> PINS_OUT.cs_n && REQ_READY_OUT;
    endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("read pins wrong");
    a_rd_adr: assert property (p_rd_adr) else $error("read address moved");
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    a_pulse: assert property (p_pulse) else $error("strobe pulse width");
    a_adr_w: assert property (p_adr_w) else $error("address moved in strobe");
    a_oe_first: assert property (p_oe_first) else $error("data driven early");
    a_hold: assert property (p_hold) else $error("write data hold");
    a_setup: assert property (p_setup) else $error("write data setup");
    a_retain: assert property (p_retain) else $error("select during retain");
endmodule : asr_host_chk
`default_nettype wire

// file: verification/asr_sram_model.sv
// Purpose : behavioural 2048 x 8 async memory on the host pins
// Assumes : host drives write data only after the memory lets go
// Notes   : contention shows as unknown; a released bus shows inverted data
`timescale 1ns/1ns
`default_nettype none
module asr_sram (
    input  wire asr_pkg::asr_pins_s pins_in,
    input  wire logic [7:0]         host_dq_in,
    input  wire logic               host_oe_in,
    output var  logic [7:0]         dq_out
);
    logic [7:0] mem [0:2047];
    logic [7:0] last = 8'h00;
    wire        drv;
    // release lags by 40 ns, inside both the 40 ns and 60 ns limits
    assign #(0,40) drv = !pins_in.cs_n && !pins_in.oe_n && pins_in.we_n;
    always @* begin
        if (drv) last = mem[pins_in.addr];
        else if (host_oe_in) last = host_dq_in;
        dq_out = (drv && host_oe_in) ? 8'hXX : ((drv || host_oe_in) ? last : ~last);
    end
    always @(posedge pins_in.we_n) begin
        if (!pins_in.cs_n) mem[pins_in.addr] <= host_dq_in;
    end
endmodule : asr_sram
`default_nettype wire

// file: verification/test_asr_host.sv
// Purpose : self-checking bench for asr_host against a memory model
// Assumes : one request at a time, clock enable dropped only while idle
// Notes   : random addresses sit in two corners so reads hit written bytes
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_asr_host;
    logic clk = 1'b0, rst = 1'b1, valid = 1'b0, retain = 1'b0, clk_en = 1'b1;
    asr_pkg::asr_req_s  req = '0;
    asr_pkg::asr_pins_s pins;
    logic [7:0]  dq_in, dq_out, rd_data, d;
    logic        ready, rd_v, wr_d, dq_oe;
    logic [10:0] a;
    logic [7:0]  shadow [0:2047];
    int          error_cnt = 0, n_checks = 0;
    always #5 clk = ~clk;
    asr_host u_asr_host (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(clk_en),
        .REQ_VALID_IN(valid), .REQ_IN(req), .RETAIN_IN(retain), .DQ_IN(dq_in),
        .REQ_READY_OUT(ready), .RD_VALID_OUT(rd_v), .RD_DATA_OUT(rd_data),
        .WR_DONE_OUT(wr_d), .PINS_OUT(pins), .DQ_OUT(dq_out), .DQ_OE_OUT(dq_oe));
    asr_sram u_asr_sram (.pins_in(pins),
        .host_dq_in(dq_out), .host_oe_in(dq_oe), .dq_out(dq_in));
    // ============================================================
    // tasks
    // edges from take to answer: read waits the cycle time, write walks its phases
    function automatic int exp_cyc(input logic w);
        if (w) exp_cyc = 1 + asr_pkg::SETUP_CYC + asr_pkg::HIZ_WAIT_CYC
            + asr_pkg::STORE_PULSE_CYC + asr_pkg::HOLD_CYC + asr_pkg::RECOVERY_CYC;
        else exp_cyc = asr_pkg::ACCESS_CYC + 1;
    endfunction : exp_cyc
    task automatic op(input logic w, input logic [10:0] ad, input logic [7:0] wd);
        int n;
        n = 0;
        req   <= '{write: w, addr: ad, wdata: wd};
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (!(rd_v | wr_d) && n < 40);
        `CHK(n, exp_cyc(w))
        if (w) shadow[ad] = wd;
        else `CHK(rd_data, shadow[ad])
    endtask : op
    task automatic close_out;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    // ============================================================
    // sequence
    initial begin
        void'($urandom(32'h6110));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        op(1'b1, 11'h000, 8'h00);
        op(1'b1, 11'h7FF, 8'hFF);
        op(1'b0, 11'h000, 8'h00);
        `CHK(pins.cs_n, 1'b0)
        op(1'b0, 11'h7FF, 8'h00); // back-to-back reads keep select low
        // requests offered during retention must be ignored
        retain <= 1'b1;
        valid  <= 1'b1;
        req    <= '{write: 1'b1, addr: 11'h7FF, wdata: 8'h5A};
        repeat (10) @(posedge clk);
        `CHK({ready, pins.cs_n}, 2'b11)
        retain <= 1'b0;
        valid  <= 1'b0;
        @(posedge clk);
        op(1'b0, 11'h7FF, 8'h00);
        // a frozen clock enable must leave a pending write untaken
        clk_en <= 1'b0;
        valid  <= 1'b1;
        req    <= '{write: 1'b1, addr: 11'h000, wdata: 8'hA5};
        repeat (5) @(posedge clk);
        `CHK({ready, rd_v, wr_d}, 3'b100)
        clk_en <= 1'b1;
        valid  <= 1'b0;
        @(posedge clk);
        op(1'b0, 11'h000, 8'h00);
        for (int i = 0; i < 60; i++) begin
            a = 11'($urandom % 8) | (($urandom % 2) ? 11'h7F8 : 11'h000);
            d = 8'($urandom);
            op(($urandom % 2) || $isunknown(shadow[a]), a, d);
        end
        close_out();
    end
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
endmodule : test_asr_host
bind asr_host asr_host_chk u_asr_host_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
    .CLK_EN_IN(CLK_EN_IN), .REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN),
    .RETAIN_IN(RETAIN_IN), .REQ_READY_OUT(REQ_READY_OUT), .RD_VALID_OUT(RD_VALID_OUT),
    .WR_DONE_OUT(WR_DONE_OUT), .PINS_OUT(PINS_OUT), .DQ_OUT(DQ_OUT), .DQ_OE_OUT(DQ_OE_OUT));
`default_nettype wire
